// ---- hdl/clk_ctrl_pkg.sv ----
// Purpose: constants and types for the CPU clock generator control
// Assumes: one reference clock; CPU clock edges come out as enable pulses
// Notes: register sits at its printed address on the CPU data port
package clk_ctrl_pkg;
    localparam logic [15:0] CTRL_ADDR = 16'hFFFB;
    localparam logic [7:0] CTRL_RESET = 8'h04;
    localparam int BIT_OSC_STOP = 7;
    localparam int BIT_FB_OFF = 6;
    localparam int BIT_ON_SUB = 5;
    localparam int BIT_SRC_SEL = 4;
    localparam int BIT_ZERO = 3;
    localparam int STAB_CYCLES = 131072;
    localparam int SWITCH_WAIT_INSTR = 16;
    localparam int INSTR_CPU_CLOCKS = 2;
    localparam int SYNC_STAGES = 2;
    localparam logic [2:0] DIV_MAX = 3'h4;

    typedef struct packed {
        logic main_osc_stop;
        logic sub_feedback_off;
        logic cpu_on_sub_status;
        logic src_sel;
        logic zero_bit;
        logic [2:0] divide_sel;
    } ctrl_reg_t;

    typedef struct packed {
        logic wr_en;
        logic bit_op;
        logic [2:0] bit_idx;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cpu_wr_t;

    typedef struct packed {
        logic main_osc_run;
        logic sub_fb_enable;
        logic cpu_clk_en;
        logic periph_clk_en;
        logic cpu_start;
    } clk_out_t;
endpackage

// ---- hdl/cpu_clock_generator_control.sv ----
// Purpose: CPU clock selection, divider and oscillator control
// Assumes: ref_clk is the main oscillator clock; sub clock is a pin
// Notes: CPU clock is a one-cycle enable on ref_clk; peripheral enable stays high while the main clock runs once the stabilisation count is done
`timescale 1ns/10ps
module cpu_clock_generator_control #(
    parameter int STAB_WAIT = clk_ctrl_pkg::STAB_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire clk_ctrl_pkg::cpu_wr_t cpu_wr,
    input wire logic stop_instr,
    input wire logic stop_release,
    input wire logic sub_clk_in,
    output logic [7:0] rdata_q,
    output clk_ctrl_pkg::clk_out_t clk_out_q,
    output logic [3:0] prescale_q,
    output logic watch_clk_q
);
    import clk_ctrl_pkg::*;

    ctrl_reg_t ctrl_q;
    ctrl_reg_t ctrl_d;
    logic [3:0] div_cnt_q;
    logic [17:0] stab_q;
    logic stop_mode_q;
    logic sub_level;
    logic sub_rise;
    logic sub_half_q;
    logic src_active_q;
    logic [2:0] div_active_q;
    logic [5:0] switch_cnt_q;
    logic sel_hit;
    logic [7:0] merged;
    logic main_tick;
    logic sub_tick;
    logic cpu_tick;
    logic cpu_period_end;
    logic switch_pending;
    logic osc_allowed;
    logic stab_done;
    logic switch_due;
    logic div_load;
    logic [5:0] switch_cnt_d;
    logic fb_enable_d;
    logic watch_d;
    logic periph_d;

    // Subsystem clock crosses in through two flops
    // Its edges reach the CPU three to four ref cycles late
    edge_sync u_sub_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(sub_clk_in),
        .level_q(sub_level),
        .rise_q(sub_rise)
    );

    // Bit or byte write merge
    // Only the one exact address decodes; nothing is mirrored
    assign sel_hit = cpu_wr.wr_en && (cpu_wr.addr == CTRL_ADDR);
    always_comb begin
        merged = ctrl_q;
        if (cpu_wr.bit_op) begin
            merged[cpu_wr.bit_idx] = cpu_wr.wdata[cpu_wr.bit_idx];
        end else begin
            merged = cpu_wr.wdata;
        end
    end

    // Status bit kept from hardware, bit 3 held zero
    always_comb begin
        ctrl_d = ctrl_q;
        if (sel_hit) begin
            ctrl_d = ctrl_reg_t'(merged);
            ctrl_d.zero_bit = 1'b0;
        end
        ctrl_d.cpu_on_sub_status = src_active_q;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= ctrl_reg_t'(CTRL_RESET);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Free-running prescaler on the main clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= 4'h0;
        end else if (osc_allowed) begin
            div_cnt_q <= div_cnt_q + 4'h1;
        end
    end

    // One tick per divided main period
    // At ratio 16 the shifted one falls off, so the mask is all ones
    assign main_tick = osc_allowed && stab_done &&
                       ((div_cnt_q & ((4'h1 << div_active_q) - 4'h1)) == 4'h0);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_half_q <= 1'b0;
        end else if (sub_rise) begin
            sub_half_q <= ~sub_half_q;
        end
    end
    assign sub_tick = sub_rise && sub_half_q;

    // CPU edge from whichever source is active
    assign cpu_tick = src_active_q ? sub_tick : main_tick;

    // Instruction boundary every two CPU clocks
    logic instr_phase_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_phase_q <= 1'b0;
        end else if (cpu_tick) begin
            instr_phase_q <= ~instr_phase_q;
        end
    end
    assign cpu_period_end = cpu_tick && instr_phase_q;

    // Hold old selection for some instructions
    assign switch_pending = (ctrl_q.src_sel != src_active_q) ||
                            (!ctrl_q.src_sel && ctrl_q.divide_sel <= DIV_MAX &&
                             ctrl_q.divide_sel != div_active_q);
    // Change lands on the last boundary of the wait
    assign switch_due = switch_pending && cpu_period_end &&
                        (switch_cnt_q >= 6'(SWITCH_WAIT_INSTR - 1));
    // Prohibited codes never reach the active ratio
    assign div_load = switch_due && !ctrl_q.src_sel && (ctrl_q.divide_sel <= DIV_MAX);
    // Counter clears whenever nothing waits; a rewrite to another new value keeps the count
    assign switch_cnt_d = (!switch_pending || switch_due) ? 6'h0 :
                          (cpu_period_end ? switch_cnt_q + 6'h1 : switch_cnt_q);

    // Instruction boundaries counted while a change waits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            switch_cnt_q <= 6'h0;
        end else begin
            switch_cnt_q <= switch_cnt_d;
        end
    end

    // Source flips only at an instruction boundary, so no runt edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_active_q <= 1'b0;
        end else if (switch_due) begin
            src_active_q <= ctrl_q.src_sel;
        end
    end

    // Active divide ratio, loaded with the switch
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_active_q <= DIV_MAX;
        end else if (div_load) begin
            div_active_q <= ctrl_q.divide_sel;
        end
    end

    // Stop instruction parks the main oscillator until release
    // Stop is ignored while the sub clock drives the CPU
    // Request beats a release in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_mode_q <= 1'b0;
        end else if (stop_instr && !src_active_q) begin
            stop_mode_q <= 1'b1;
        end else if (stop_release) begin
            stop_mode_q <= 1'b0;
        end
    end

    // Stop bit honoured only on subsystem operation
    // Keeps the CPU from losing its only clock mid-instruction
    assign osc_allowed = !stop_mode_q && !(ctrl_q.main_osc_stop && src_active_q);

    // Stabilisation count after reset release
    // Not re-armed after a stop; software waits before switching back
    assign stab_done = (stab_q >= 18'(STAB_WAIT));
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stab_q <= 18'h0;
        end else if (!stab_done) begin
            stab_q <= stab_q + 18'h1;
        end
    end

    // Resistor follows the value being written, not last cycle's
    assign fb_enable_d = !ctrl_d.sub_feedback_off;
    // Peripherals tick only once the main clock is up and steady
    assign periph_d = osc_allowed && stab_done;
    // Watch clock gated off once the resistor is out
    assign watch_d = sub_level && !ctrl_q.sub_feedback_off;

    // Outputs low under reset; sub feedback only via bit 6
    // Peripheral tick from main only, watch clock from sub
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_out_q <= '0;
            rdata_q <= 8'h00;
            prescale_q <= 4'h0;
            watch_clk_q <= 1'b0;
        end else begin
            clk_out_q.main_osc_run <= osc_allowed;
            clk_out_q.sub_fb_enable <= fb_enable_d;
            clk_out_q.cpu_clk_en <= cpu_tick;
            clk_out_q.periph_clk_en <= periph_d;
            clk_out_q.cpu_start <= stab_done;
            // Bit 7 read back as written
            rdata_q <= ctrl_d;
            prescale_q <= div_cnt_q;
            watch_clk_q <= watch_d;
        end
    end
endmodule

// ---- hdl/edge_sync.sv ----
// Purpose: two-stage synchroniser with rising edge pulse
// Assumes: input comes from another clock domain
// Notes: edge detect reads only the second stage
`timescale 1ns/10ps
module edge_sync (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic level_q,
    output logic rise_q
);
    logic meta_q;
    logic last_q;
    // First stage feeds only the second
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            level_q <= 1'b0;
            last_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            level_q <= meta_q;
            last_q <= level_q;
            rise_q <= level_q & ~last_q;
        end
    end
endmodule

// ---- sim/clk_ctrl_chk.sv ----
// Purpose: port assertions for the CPU clock control block
// Assumes: one ref_clk domain, async active-low reset
// Notes: stop_seen_q masks the main-hold check once stop mode was used
`timescale 1ns/10ps
module clk_ctrl_chk #(
    parameter int STAB_WAIT = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire clk_ctrl_pkg::cpu_wr_t cpu_wr,
    input wire logic stop_instr,
    input wire logic [7:0] rdata_q,
    input wire clk_ctrl_pkg::clk_out_t clk_out_q,
    input wire logic watch_clk_q
);
    import clk_ctrl_pkg::*;
    logic stop_seen_q;
    int cnt_q;
    // Cycles since reset, saturating so it cannot wrap
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 0;
            stop_seen_q <= 1'b0;
        end else begin
            cnt_q <= (cnt_q < 1000) ? cnt_q + 1 : cnt_q;
            stop_seen_q <= stop_seen_q | stop_instr;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence byte_wr_s;
        cpu_wr.wr_en && cpu_wr.addr == CTRL_ADDR && !cpu_wr.bit_op && cpu_wr.wdata[2:0] <= DIV_MAX;
    endsequence
    sequence fb_off_s;
        rdata_q[6] [*5];
    endsequence
    osc_in_reset_a:
        assert property (disable iff (1'b0) !rst_n |-> !clk_out_q.main_osc_run) else $error("osc runs in reset");
    reset_value_a:
        assert property ($rose(rst_n) |=> rdata_q == CTRL_RESET && clk_out_q.main_osc_run) else $error("bad reset");
    byte_write_a:
        assert property (byte_wr_s |=> rdata_q[7:6] == $past(cpu_wr.wdata[7:6])
            && rdata_q[4:0] == {$past(cpu_wr.wdata[4]), 1'b0, $past(cpu_wr.wdata[2:0])}) else $error("write lost");
    zero_bit_a:
        assert property (!rdata_q[3]) else $error("bit 3 set");
    fb_off_a:
        assert property (rdata_q[6] && $past(rdata_q[6]) |-> !clk_out_q.sub_fb_enable) else $error("fb on");
    watch_low_a:
        assert property (fb_off_s |-> !watch_clk_q) else $error("watch clock alive");
    osc_hold_a:
        assert property (rdata_q[7] && !rdata_q[5] && !stop_seen_q |-> clk_out_q.main_osc_run) else $error("early stop");
    osc_stop_a:
        assert property (rdata_q[7] && rdata_q[5] |-> ##[0:2] !clk_out_q.main_osc_run) else $error("osc not stopped");
    sub_source_a:
        assert property ($rose(rdata_q[5]) |-> rdata_q[4]) else $error("sub status without select");
    start_wait_a:
        assert property ($rose(clk_out_q.cpu_start) |-> cnt_q >= STAB_WAIT && cnt_q <= STAB_WAIT + 3)
            else $error("start time off");
endmodule
bind cpu_clock_generator_control clk_ctrl_chk #(.STAB_WAIT(STAB_WAIT)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .cpu_wr(cpu_wr), .stop_instr(stop_instr), .rdata_q(rdata_q), .clk_out_q(clk_out_q), .watch_clk_q(watch_clk_q));

// ---- sim/cpu_side_model.sv ----
// Purpose: CPU-side stand-in, sub crystal plus CPU tick counter
// Assumes: sub crystal near 32.768 kHz, unrelated to ref_clk
// Notes: counts ticks only; the core itself is not modelled
`timescale 1ns/10ps
module cpu_side_model (
    input wire logic ref_clk,
    input wire logic cpu_clk_en,
    output logic sub_clk,
    output int ticks
);
    // Sub crystal runs free, never stopped
    initial begin
        sub_clk = 1'b0;
        forever #15259 sub_clk = ~sub_clk;
    end
    // Ticks seen by the core; two make one instruction
    always @(posedge ref_clk) if (cpu_clk_en) ticks <= ticks + 1;
endmodule

// ---- sim/test_cpu_clock_generator_control.sv ----
// Purpose: directed test of the CPU clock control block
// Assumes: short stabilisation wait of 16 cycles
// Notes: inputs change on falling edges only
`timescale 1ns/10ps
module test_cpu_clock_generator_control;
    import clk_ctrl_pkg::*;
    logic ref_clk, rst_n, stop_instr, stop_release, sub_clk_in, watch_clk_q;
    cpu_wr_t cpu_wr;
    logic [7:0] rdata_q;
    clk_out_t clk_out_q;
    logic [3:0] prescale_q, p0;
    int n_errors, check_count, ticks, t0, i;
    cpu_clock_generator_control #(.STAB_WAIT(16)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cpu_wr(cpu_wr),
        .stop_instr(stop_instr), .stop_release(stop_release), .sub_clk_in(sub_clk_in), .rdata_q(rdata_q),
        .clk_out_q(clk_out_q), .prescale_q(prescale_q), .watch_clk_q(watch_clk_q));
    cpu_side_model u_cpu (.ref_clk(ref_clk), .cpu_clk_en(clk_out_q.cpu_clk_en), .sub_clk(sub_clk_in), .ticks(ticks));
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task print_verdict;
        if (n_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Bit or byte write to the control register
    task wr(input logic b, input logic [2:0] idx, input logic [7:0] d);
        @(negedge ref_clk);
        cpu_wr = '{1'b1, b, idx, CTRL_ADDR, d};
        idle(1);
        cpu_wr.wr_en = 1'b0;
        idle(1);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Worst-case waits add up near 47k cycles; give up at 60k
    initial begin
        #6000000;
        n_errors++;
        print_verdict;
    end
    initial begin
        rst_n = 1'b0;
        stop_instr = 1'b0;
        stop_release = 1'b0;
        cpu_wr = '0;
        idle(10);
        chk1(clk_out_q.main_osc_run, 1'b0);
        rst_n = 1'b1;
        idle(1);
        chk8(rdata_q, 8'h04);
        for (i = 0; i < 40 && clk_out_q.cpu_start !== 1'b1; i++) idle(1);
        chk1(clk_out_q.cpu_start, 1'b1);
        chk1(clk_out_q.periph_clk_en, 1'b1);
        p0 = prescale_q;
        idle(1);
        chk8({4'h0, prescale_q}, {4'h0, p0 + 4'h1});
        // Divider codes 0 to 4, tick rate after the switch delay
        for (i = 0; i < 5; i++) begin
            wr(1'b0, 3'h0, 8'(i));
            chk8(rdata_q, 8'(i));
            idle(600);
            t0 = ticks;
            idle(160);
            chk8(8'(ticks - t0), 8'(160 >> i));
        end
        // Read-only status, zero bit and a prohibited code
        wr(1'b0, 3'h0, 8'h29);
        chk8(rdata_q, 8'h01);
        wr(1'b0, 3'h0, 8'h0D);
        chk8(rdata_q, 8'h05);
        t0 = ticks;
        idle(160);
        chk8(8'(ticks - t0), 8'h0A);
        wr(1'b1, 3'h6, 8'h40);
        idle(8);
        chk8(rdata_q, 8'h45);
        chk1(watch_clk_q, 1'b0);
        chk1(clk_out_q.sub_fb_enable, 1'b0);
        wr(1'b1, 3'h6, 8'h00);
        wr(1'b0, 3'h0, 8'h80);
        idle(600);
        chk1(clk_out_q.main_osc_run, 1'b1);
        wr(1'b1, 3'h4, 8'h10);
        for (i = 0; i < 2000 && rdata_q[5] !== 1'b1; i++) idle(1);
        idle(2);
        chk8(rdata_q, 8'hB0);
        chk1(clk_out_q.main_osc_run, 1'b0);
        chk1(clk_out_q.periph_clk_en, 1'b0);
        p0[0] = watch_clk_q;
        for (i = 0; i < 400 && watch_clk_q === p0[0]; i++) idle(1);
        chk1(watch_clk_q, ~p0[0]);
        wr(1'b0, 3'h0, 8'h00);
        for (i = 0; i < 40000 && rdata_q[5] !== 1'b0; i++) idle(1);
        chk8(rdata_q, 8'h00);
        chk1(clk_out_q.main_osc_run, 1'b1);
        stop_instr = 1'b1;
        idle(1);
        stop_instr = 1'b0;
        idle(20);
        chk1(clk_out_q.main_osc_run, 1'b0);
        stop_release = 1'b1;
        idle(1);
        stop_release = 1'b0;
        idle(20);
        chk1(clk_out_q.main_osc_run, 1'b1);
        print_verdict;
    end
endmodule
